// ==== rtl/cbw_pkg.sv ====
package cbw_pkg;

  // ------------------------------------------------------------
  // timing base
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_TIME_NS  = 62_500_000;
  localparam int unsigned TICK_CYCLES_DFLT = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W = 22;

  // ------------------------------------------------------------
  // tick counts (one tick is 62.5 ms)
  // ------------------------------------------------------------
  localparam logic [3:0] SEC_LAST_TICK  = 4'hF;
  localparam logic [2:0] HALF_LAST_TICK = 3'h7;
  localparam logic [9:0] WIN_LAST_TICK  = 10'h3BF;
  localparam logic [9:0] DUTY_STEP_TICKS = 10'h078;
  localparam logic [15:0] TIMEOUT_STEP_MIN = 16'h0078;

  // ------------------------------------------------------------
  // field codes and cell groups
  // ------------------------------------------------------------
  localparam int unsigned CELLS = 12;
  localparam logic [2:0]  PRESCALE_OFF = 3'h0;
  localparam logic [3:0]  COUNT_ZERO   = 4'h0;
  localparam logic [7:0]  TIMEOUT_ZERO = 8'h00;
  localparam logic [11:0] ODD_CELLS    = 12'h555;
  localparam logic [11:0] EVEN_CELLS   = 12'hAAA;
  localparam logic [11:0] ALL_OFF      = 12'h000;

  typedef enum logic [1:0] {
    DIS_IDLE = 2'b00,
    DIS_ON   = 2'b01,
    DIS_OFF  = 2'b11
  } dis_state_type;

  // seconds per watchdog step, one less than the step
  function automatic logic [8:0] step_last_sec(input logic [2:0] code);
    unique case (code)
      3'h1:    step_last_sec = 9'h000;
      3'h2:    step_last_sec = 9'h003;
      3'h3:    step_last_sec = 9'h00F;
      3'h4:    step_last_sec = 9'h03F;
      3'h5:    step_last_sec = 9'h07F;
      default: step_last_sec = 9'h0FF;
    endcase
  endfunction : step_last_sec

  // on-time in ticks, clipped to leave the final off tick
  function automatic logic [9:0] on_ticks(input logic [2:0] duty);
    logic [9:0] t;
    t = 10'(({7'h00, duty} + 10'h001) * DUTY_STEP_TICKS);
    on_ticks = (t > WIN_LAST_TICK) ? WIN_LAST_TICK : t;
  endfunction : on_ticks

endpackage : cbw_pkg

// ==== rtl/tick_if.sv ====
`timescale 1ns/1ps
interface tick_if;
  logic tick;
  logic restart;
  modport src (output tick, input restart);
  modport snk (input tick, output restart);
endinterface : tick_if

// ==== rtl/tick_gen.sv ====
`timescale 1ns/1ps
module tick_gen
  import cbw_pkg::*;
#(
  parameter int unsigned PERIOD = TICK_CYCLES_DFLT
) (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  tick_if.src       tk
);

  logic [TICK_CNT_W-1:0] cnt_r;
  logic                  tick_r;
  localparam logic [TICK_CNT_W-1:0] LAST = TICK_CNT_W'(PERIOD - 1);

  assign tk.tick = tick_r;

  // restart realigns the tick so periods count from a host action
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || tk.restart) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (cnt_r == LAST) begin
      cnt_r  <= '0;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

endmodule : tick_gen

// ==== rtl/cell_balance_watchdog_discharge.sv ====
// Notes on behaviour
// - watchdog expiry turns every balancing switch off
// - expiry gates outputs, stored enable pattern kept
// - prescale code picks step period, zero disables
// - four-bit countdown, one step per period
// - expired stays off until disabled or reloaded
// - timer-output bit drives pin three while counting
// - discharge starts on enable with nonzero timeout
// - discharge entry clears the watchdog countdown
// - discharge switches follow the discharge select
// - discharge entry starts the timeout countdown
// - heartbeat counts at 2 Hz, wraps after F
// - pin three high while discharge runs
// - alternate one-minute odd and even windows
// - each window ends with at least 62.5 ms off
// - duty code sets on-time in 7.5 s steps
// - timeout code sets duration, 2 h steps
// - clearing enable ends mode, restores normal control
// - zero timeout or elapsed duration ends mode
`timescale 1ns/1ps
module cell_balance_watchdog_discharge
  import cbw_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  // normal balancing and watchdog control
  input  wire logic [CELLS-1:0]  normal_switch_enable_in,
  input  wire logic [2:0]        watchdog_prescale_in,
  input  wire logic [3:0]        watchdog_countdown_in,
  input  wire logic              watchdog_countdown_wr_in,
  input  wire logic              pin3_timer_output_enable_in,
  // emergency discharge control
  input  wire logic              emergency_discharge_enable_in,
  input  wire logic [CELLS-1:0]  discharge_switch_select_in,
  input  wire logic [7:0]        discharge_timeout_in,
  input  wire logic [2:0]        discharge_duty_window_in,
  // pin three general-purpose setting
  input  wire logic              pin3_gp_level_in,
  input  wire logic              pin3_gp_oe_in,
  // switches and pin
  output logic [CELLS-1:0]       switch_out,
  output logic                   general_pin_three_out,
  output logic                   general_pin_three_oe_out,
  // status
  output logic [3:0]             watchdog_countdown_out,
  output logic                   watchdog_expired_out,
  output logic                   discharge_active_out,
  output logic [3:0]             discharge_heartbeat_out
);

  // ------------------------------------------------------------
  // tick source
  // ------------------------------------------------------------
  tick_if tk ();

  tick_gen #(
    .PERIOD (TICK_CYCLES)
  ) u_tick (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .tk         (tk)
  );

  // ------------------------------------------------------------
  // working state
  // ------------------------------------------------------------
  logic [3:0]    wd_cnt_r;
  logic [3:0]    sec_tick_r;
  logic [8:0]    step_sec_r;
  dis_state_type dis_state_r;
  logic          dis_done_r;
  logic          odd_phase_r;
  logic [9:0]    win_tick_r;
  logic [15:0]   win_min_r;
  logic [2:0]    half_tick_r;
  logic [3:0]    heartbeat_r;
  logic [CELLS-1:0] switch_r;
  logic          pin3_r;
  logic          pin3_oe_r;
  logic          expired_r;

  logic          wd_write;
  logic          wd_enabled;
  logic          wd_running;
  logic          sec_pulse;
  logic          step_pulse;
  logic          dis_active;
  logic          dis_start;
  logic          dis_stop;
  logic          win_end;
  logic          on_end;
  logic [15:0]   timeout_min;
  logic          wd_gate;
  logic          active_r;
  logic [CELLS-1:0] switch_nxt;
  logic          pin3_nxt;
  logic          pin3_oe_nxt;

  // ------------------------------------------------------------
  // decodes
  // ------------------------------------------------------------
  assign wd_write   = watchdog_countdown_wr_in;
  assign wd_enabled = (watchdog_prescale_in != PRESCALE_OFF);
  assign dis_active = (dis_state_r != DIS_IDLE);
  assign wd_running = wd_enabled && (wd_cnt_r != COUNT_ZERO) && !dis_active;
  // an empty count under a set prescale gates, even before any write
  assign wd_gate    = wd_enabled && (wd_cnt_r == COUNT_ZERO);
  assign sec_pulse  = tk.tick && (sec_tick_r == SEC_LAST_TICK);
  assign step_pulse = sec_pulse
                      && (step_sec_r == step_last_sec(watchdog_prescale_in));

  // limit in minutes: base step plus 2 h per code step
  assign timeout_min = 16'((16'(discharge_timeout_in) + 16'h0001)
                           * TIMEOUT_STEP_MIN);

  assign dis_start = emergency_discharge_enable_in
                     && (discharge_timeout_in != TIMEOUT_ZERO)
                     && !dis_active && !dis_done_r;
  assign dis_stop  = dis_active
                     && (!emergency_discharge_enable_in
                         || (discharge_timeout_in == TIMEOUT_ZERO)
                         || (win_min_r >= timeout_min));
  assign win_end   = tk.tick && (win_tick_r == WIN_LAST_TICK);
  assign on_end    = tk.tick
                     && (win_tick_r == on_ticks(discharge_duty_window_in) - 10'h001);

  // restart the tick so each period counts from the host action
  assign tk.restart = wd_write || dis_start;

  // ------------------------------------------------------------
  // watchdog prescaler
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || wd_write || !wd_running) begin
      sec_tick_r <= '0;
      step_sec_r <= '0;
    end else if (tk.tick) begin
      sec_tick_r <= sec_tick_r + 4'h1;
      if (sec_pulse) begin
        step_sec_r <= step_pulse ? 9'h000 : step_sec_r + 9'h001;
      end
    end
  end

  // ------------------------------------------------------------
  // watchdog countdown
  // ------------------------------------------------------------
  // discharge entry wins over a host write in the same cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wd_cnt_r <= COUNT_ZERO;
    end else if (dis_start) begin
      wd_cnt_r <= COUNT_ZERO;
    end else if (wd_write) begin
      wd_cnt_r <= watchdog_countdown_in;
    end else if (wd_running && step_pulse) begin
      wd_cnt_r <= wd_cnt_r - 4'h1;
    end
  end

  // ------------------------------------------------------------
  // discharge sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dis_state_r <= DIS_IDLE;
    end else if (dis_stop) begin
      dis_state_r <= DIS_IDLE;
    end else begin
      unique case (dis_state_r)
        DIS_IDLE: begin
          if (dis_start) begin
            dis_state_r <= DIS_ON;
          end
        end
        DIS_ON: begin
          if (on_end) begin
            dis_state_r <= DIS_OFF;
          end
        end
        DIS_OFF: begin
          if (win_end) begin
            dis_state_r <= DIS_ON;
          end
        end
        // unused code 2'b10 only comes from an upset; fall back to idle
        default: begin
          dis_state_r <= DIS_IDLE;
        end
      endcase
    end
  end

  // registered mode flag so the status output comes from a flop
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || dis_stop) begin
      active_r <= 1'b0;
    end else if (dis_start) begin
      active_r <= 1'b1;
    end
  end

  // blocks a silent re-entry after a timeout until enable drops
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !emergency_discharge_enable_in) begin
      dis_done_r <= 1'b0;
    end else if (dis_stop) begin
      dis_done_r <= 1'b1;
    end
  end

  // window position, restarted each window so on-time counts from its start
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !dis_active) begin
      win_tick_r <= '0;
    end else if (win_end) begin
      win_tick_r <= '0;
    end else if (tk.tick) begin
      win_tick_r <= win_tick_r + 10'h001;
    end
  end

  // cell group; idle parks it on odd so every session opens odd
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !dis_active) begin
      odd_phase_r <= 1'b1;
    end else if (win_end) begin
      odd_phase_r <= !odd_phase_r;
    end
  end

  // elapsed minutes toward the timeout
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !dis_active) begin
      win_min_r <= '0;
    end else if (win_end) begin
      win_min_r <= win_min_r + 16'h0001;
    end
  end

  // half-second divider, eight ticks per beat
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || dis_start) begin
      half_tick_r <= '0;
    end else if (dis_active && tk.tick) begin
      half_tick_r <= half_tick_r + 3'h1;
    end
  end

  // heartbeat wraps by itself and holds after exit so a late read still sees it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || dis_start) begin
      heartbeat_r <= '0;
    end else if (dis_active && tk.tick && (half_tick_r == HALF_LAST_TICK)) begin
      heartbeat_r <= heartbeat_r + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // switch outputs
  // ------------------------------------------------------------
  // stored enable pattern is never touched, only the outputs are gated;
  // a reload lifts the gate one cycle late, in step with the expired flag
  always_comb begin
    if (dis_active && !dis_stop) begin
      if (dis_state_r == DIS_ON && !on_end) begin
        switch_nxt = discharge_switch_select_in
                     & (odd_phase_r ? ODD_CELLS : EVEN_CELLS);
      end else begin
        switch_nxt = ALL_OFF;
      end
    end else if (wd_gate) begin
      switch_nxt = ALL_OFF;
    end else begin
      switch_nxt = normal_switch_enable_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      switch_r <= ALL_OFF;
    end else begin
      switch_r <= switch_nxt;
    end
  end

  // ------------------------------------------------------------
  // pin three
  // ------------------------------------------------------------
  // either timer takes the pin over from its general-purpose setting
  always_comb begin
    if (dis_active && !dis_stop) begin
      pin3_nxt    = 1'b1;
      pin3_oe_nxt = 1'b1;
    end else if (pin3_timer_output_enable_in && wd_running) begin
      pin3_nxt    = 1'b1;
      pin3_oe_nxt = 1'b1;
    end else begin
      pin3_nxt    = pin3_gp_level_in;
      pin3_oe_nxt = pin3_gp_oe_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin3_r    <= 1'b0;
      pin3_oe_r <= 1'b0;
    end else begin
      pin3_r    <= pin3_nxt;
      pin3_oe_r <= pin3_oe_nxt;
    end
  end

  // ------------------------------------------------------------
  // status
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      expired_r <= 1'b0;
    end else begin
      expired_r <= wd_gate && !dis_active;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign switch_out               = switch_r;
  assign general_pin_three_out    = pin3_r;
  assign general_pin_three_oe_out = pin3_oe_r;
  assign watchdog_countdown_out   = wd_cnt_r;
  assign watchdog_expired_out     = expired_r;
  assign discharge_active_out     = active_r;
  assign discharge_heartbeat_out  = heartbeat_r;

endmodule : cell_balance_watchdog_discharge

// ==== bench/cbw_assertions.sv ====
`timescale 1ns/1ps
module cbw_checker
  import cbw_pkg::*;
(
  // clock, reset and controls
  input wire logic             clk_in,
  input wire logic             sys_rst_in,
  input wire logic [3:0]       watchdog_countdown_in,
  input wire logic             watchdog_countdown_wr_in,
  input wire logic             emergency_discharge_enable_in,
  input wire logic [7:0]       discharge_timeout_in,
  // outputs under watch
  input wire logic [CELLS-1:0] switch_out,
  input wire logic             general_pin_three_out,
  input wire logic             general_pin_three_oe_out,
  input wire logic [3:0]       watchdog_countdown_out,
  input wire logic             watchdog_expired_out,
  input wire logic             discharge_active_out,
  input wire logic [3:0]       discharge_heartbeat_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  expiry_gates_a: assert property (
    watchdog_expired_out |-> switch_out == ALL_OFF) else $error("switches on after expiry");
  entry_clears_a: assert property (
    $rose(discharge_active_out) |-> watchdog_countdown_out == COUNT_ZERO)
    else $error("countdown kept on discharge entry");
  entry_cause_a: assert property (
    $rose(discharge_active_out) |-> $past(emergency_discharge_enable_in)
    && $past(discharge_timeout_in) != TIMEOUT_ZERO) else $error("discharge entered wrongly");
  exit_cause_a: assert property (
    !emergency_discharge_enable_in || discharge_timeout_in == TIMEOUT_ZERO
    |=> !discharge_active_out) else $error("discharge kept running");
  pin_held_a: assert property (
    discharge_active_out && $past(discharge_active_out)
    |-> general_pin_three_out && general_pin_three_oe_out) else $error("pin low in discharge");
  group_gap_a: assert property (
    discharge_active_out && $past(discharge_active_out) && |($past(switch_out) & ODD_CELLS)
    |-> !(|(switch_out & EVEN_CELLS))) else $error("odd and even groups adjacent");
  beat_step_a: assert property (
    discharge_active_out && $past(discharge_active_out) && $changed(discharge_heartbeat_out)
    |-> discharge_heartbeat_out == $past(discharge_heartbeat_out) + 4'h1)
    else $error("heartbeat skipped");
  count_load_a: assert property (
    watchdog_countdown_wr_in && !emergency_discharge_enable_in
    |=> watchdog_countdown_out == $past(watchdog_countdown_in)) else $error("write not loaded");
  count_step_a: assert property (
    $changed(watchdog_countdown_out) && !$past(watchdog_countdown_wr_in) && !discharge_active_out
    |-> watchdog_countdown_out == $past(watchdog_countdown_out) - 4'h1)
    else $error("countdown moved by more than one");
endmodule : cbw_checker

bind cell_balance_watchdog_discharge cbw_checker chk_u (.clk_in, .sys_rst_in,
  .watchdog_countdown_in, .watchdog_countdown_wr_in, .emergency_discharge_enable_in,
  .discharge_timeout_in, .switch_out, .general_pin_three_out, .general_pin_three_oe_out,
  .watchdog_countdown_out, .watchdog_expired_out, .discharge_active_out,
  .discharge_heartbeat_out);

// ==== bench/cell_string_model.sv ====
`timescale 1ns/1ps
module cell_string_model (
  // pin three through the diode
  input  wire logic pin_level_in,
  input  wire logic pin_oe_in,
  // shutdown node seen by the cells
  output logic      hold_level_out
);
  // node is pulled down, so a released pin never reads as its last level
  assign hold_level_out = pin_oe_in & pin_level_in;
endmodule : cell_string_model

// ==== bench/cell_balance_watchdog_discharge_tb.sv ====
`timescale 1ns/1ps
module cell_balance_watchdog_discharge_tb;
  import cbw_pkg::*;
  localparam int unsigned TK = 4;
  int          steps[7] = '{0, 1, 4, 16, 64, 128, 256};
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [11:0] norm = 12'h0F3;
  logic [11:0] sel = 12'hFFF;
  logic [11:0] sw;
  logic [2:0]  presc = 3'h0;
  logic [2:0]  duty = 3'h0;
  logic [3:0]  cval = 4'h0;
  logic [3:0]  cnt;
  logic [3:0]  hb;
  logic [7:0]  tmo = 8'h00;
  logic        cwr = 1'b0;
  logic        ten = 1'b1;
  logic        den = 1'b0;
  logic        gp_lvl = 1'b0;
  logic        gp_oe = 1'b1;
  logic        pin, pin_oe, expired, active, hold;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;

  cell_balance_watchdog_discharge #(.TICK_CYCLES(TK)) dut_u (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .normal_switch_enable_in(norm), .watchdog_prescale_in(presc),
    .watchdog_countdown_in(cval), .watchdog_countdown_wr_in(cwr),
    .pin3_timer_output_enable_in(ten), .emergency_discharge_enable_in(den),
    .discharge_switch_select_in(sel), .discharge_timeout_in(tmo),
    .discharge_duty_window_in(duty), .pin3_gp_level_in(gp_lvl), .pin3_gp_oe_in(gp_oe),
    .switch_out(sw), .general_pin_three_out(pin), .general_pin_three_oe_out(pin_oe),
    .watchdog_countdown_out(cnt), .watchdog_expired_out(expired),
    .discharge_active_out(active), .discharge_heartbeat_out(hb));
  cell_string_model cells_u (.pin_level_in(pin), .pin_oe_in(pin_oe), .hold_level_out(hold));

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk_sw(input string nm, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_sw
  task automatic chk_nib(input string nm, input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_nib
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_bit
  task automatic idle(input int n);
    repeat (n) @(negedge clk_in);
  endtask : idle
  task automatic wr_count(input logic [3:0] v);
    @(negedge clk_in);
    cval = v;
    cwr = 1'b1;
    @(negedge clk_in);
    cwr = 1'b0;
  endtask : wr_count
  task automatic stop_test();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    idle(12);
    chk_sw("switch", 12'h000, sw);
    sys_rst_in = 1'b0;
    idle(3);
    chk_sw("switch", 12'h0F3, sw);
    // each step length, sampled just before and after the expected edge
    for (int c = 1; c <= 6; c++) begin
      presc = 3'(c);
      wr_count(4'h1);
      idle(steps[c] * 16 * TK - 8);
      chk_nib("count", 4'h1, cnt);
      idle(16);
      chk_nib("count", 4'h0, cnt);
      chk_sw("switch", 12'h000, sw);
    end
    chk_bit("pin", 1'b0, hold);
    wr_count(4'h3);
    idle(2);
    chk_bit("pin", 1'b1, hold);
    chk_sw("switch", 12'h0F3, sw);
    wr_count(4'h0);
    idle(3);
    chk_sw("switch", 12'h000, sw);
    chk_bit("expired", 1'b1, expired);
    presc = 3'h0;
    idle(3);
    chk_sw("switch", 12'h0F3, sw);
    presc = 3'h1;
    wr_count(4'h5);
    den = 1'b1;
    idle(4);
    chk_bit("active", 1'b0, active);
    den = 1'b0;
    idle(2);
    tmo = 8'h01;
    den = 1'b1;
    idle(2);
    chk_bit("active", 1'b1, active);
    chk_nib("count", 4'h0, cnt);
    idle(1);
    chk_sw("switch", 12'h555, sw);
    chk_bit("pin", 1'b1, hold);
    idle(465);
    chk_sw("switch", 12'h555, sw);
    idle(30);
    chk_sw("switch", 12'h000, sw);
    chk_nib("beat", 4'hF, hb);
    idle(32);
    chk_nib("beat", 4'h0, hb);
    // second window at duty code 1: twice the on-time of code 0
    duty = 3'h1;
    idle(3320);
    chk_sw("switch", 12'hAAA, sw);
    idle(900);
    chk_sw("switch", 12'hAAA, sw);
    idle(60);
    chk_sw("switch", 12'h000, sw);
    presc = 3'h0;
    den = 1'b0;
    gp_lvl = 1'b1;
    idle(2);
    chk_bit("active", 1'b0, active);
    chk_sw("switch", 12'h0F3, sw);
    chk_bit("pin", 1'b1, hold);
    gp_oe = 1'b0;
    idle(2);
    chk_bit("pin", 1'b0, hold);
    den = 1'b1;
    idle(3);
    chk_bit("active", 1'b1, active);
    tmo = 8'h00;
    idle(2);
    chk_bit("active", 1'b0, active);
    tmo = 8'h01;
    idle(3);
    chk_bit("active", 1'b0, active);
    den = 1'b0;
    idle(2);
    stop_test();
  end
endmodule : cell_balance_watchdog_discharge_tb
